/* inc/stt_pkg.sv */
// Constants shared by the system tick timer design files.
// Assumes a 32-bit APB register port with 12-bit byte addresses.
package stt_pkg;

  // Widths.
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned COUNT_W = 24;
  localparam int unsigned EVENT_W = 2;

  // Register byte offsets.
  localparam logic [11:0] OFS_CONTROL_STATUS = 12'h010;
  localparam logic [11:0] OFS_RELOAD_VALUE   = 12'h014;
  localparam logic [11:0] OFS_CURRENT_VALUE  = 12'h018;
  localparam logic [11:0] OFS_IRQ_STATUS     = 12'h01c;
  localparam logic [11:0] OFS_IRQ_MASK       = 12'h020;

  // Control/status field positions.
  localparam int unsigned BIT_ENABLE        = 0;
  localparam int unsigned BIT_TICK_INT_EN   = 1;
  localparam int unsigned BIT_CORE_CLK_SEL  = 2;
  localparam int unsigned BIT_ZERO_REACHED  = 16;
  localparam int unsigned CTRL_W            = 3;

  // Interrupt status and mask bit positions.
  localparam int unsigned EV_ZERO_REACHED = 0;
  localparam int unsigned EV_SW_CLEAR     = 1;

  // Reset values.
  localparam logic [31:0] RST_CONTROL_STATUS = 32'h0000_0000;
  localparam logic [23:0] RST_COUNT          = 24'h00_0000;
  localparam logic [1:0]  RST_EVENTS         = 2'h0;

  // Counter constants.
  localparam logic [23:0] COUNT_ONE  = 24'h00_0001;
  localparam logic [23:0] COUNT_ZERO = 24'h00_0000;

endpackage : stt_pkg

/* logic/stt_edge_sync.sv */
// Synchroniser and rising-edge detector for the alternate tick clock.
// Assumes the alternate clock is slower than half of pclk.
`timescale 1ns/100ps
module stt_edge_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      rise_pulse
);

  logic meta;
  logic sync;
  logic sync_d;

  // Two flops for the crossing; only the second feeds the edge detector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta   <= 1'b0;
      sync   <= 1'b0;
      sync_d <= 1'b0;
    end else begin
      meta   <= async_in;
      sync   <= meta;
      sync_d <= sync;
    end
  end

  // One pulse per rising edge seen after synchronisation.
  assign rise_pulse = sync & ~sync_d;

endmodule : stt_edge_sync

/* logic/stt_system_tick_timer.sv */
// System tick timer: 24-bit down counter with reload, zero flag and tick exception pend.
// Assumes an APB master on pclk and an exception controller that samples tick_pend.
// Overview of operation
// [R01] Counter is 24-bit, counts down, wraps at zero, cleared by current-value writes.
// [R02] While enabled decrement per tick to zero, then load reload value next tick.
// [R03] Zero-reached flag, bit 16, sets on every one-to-zero counter transition.
// [R04] Flag clears on control/status read and on any current-value write.
// [R05] Zero reload value holds counter at zero after reload, stopping counting.
// [R06] Current-value write of any data forces the counter to zero.
// [R07] Current value read returns live count in [23:0]; upper bits read zero.
// [R08] Reload register holds 24 bits, copied into counter on each expiry.
// [R09] Tick interrupt enable bit 1 makes reaching zero pend the tick exception.
// [R10] Software clearing the current value never pends the tick exception.
// [R11] Bit 2 selects core clock when one, alternate reference clock when zero.
// [R12] Enable bit 0 runs counter continuously when one, stops it when zero.
// [R13] Current value needs no reset initialisation; content undefined until written.
// [R14] Software should clear current value before enabling the counter.
// [R15] No read-modify-write protection; reads return a snapshot of the counter.
// [R16] Control/status register resets to all zeros.
// [R17] Alternate clock is synchronised; one decrement per detected rising edge.
`timescale 1ns/100ps
module stt_system_tick_timer #(
  parameter int unsigned COUNT_W = stt_pkg::COUNT_W
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [stt_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [stt_pkg::DATA_W-1:0]  pwdata,
  output logic                             pready,
  output logic [stt_pkg::DATA_W-1:0]       prdata,
  output logic                             pslverr,
  input  wire logic                        alt_tick_clk,
  output logic                             tick_pend,
  output logic                             irq
);

  logic [stt_pkg::CTRL_W-1:0]  ctrl;
  logic                        zero_reached_flag;
  logic [COUNT_W-1:0]          reload_value;
  logic [COUNT_W-1:0]          current_value;
  logic [stt_pkg::EVENT_W-1:0] irq_status;
  logic [stt_pkg::EVENT_W-1:0] irq_mask;
  logic                        snap_flag;
  logic [stt_pkg::EVENT_W-1:0] snap_status;
  logic [stt_pkg::DATA_W-1:0]  next_prdata;
  logic                        alt_rise;
  logic                        tick;
  logic                        setup_rd;
  logic                        wr_done;
  logic                        rd_done;
  logic                        mapped;
  logic                        cvr_write;
  logic                        csr_read;
  logic                        irq_read;
  logic                        reaches_zero;
  logic                        flag_set;
  logic [stt_pkg::EVENT_W-1:0] ev_set;

  // True when the bus address selects the register at the given offset.
  function automatic logic hits(input logic [stt_pkg::ADDR_W-1:0] addr,
                                input logic [stt_pkg::ADDR_W-1:0] ofs);
    hits = (addr == ofs);
  endfunction : hits

  // Alternate reference clock brought into the pclk domain.
  stt_edge_sync u_alt_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .async_in   (alt_tick_clk),
    .rise_pulse (alt_rise)
  );

  // Every transfer finishes in its first access cycle, so pready never stalls.
  assign pready   = 1'b1;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_done  = psel & penable & pwrite;
  assign rd_done  = psel & penable & ~pwrite;

  // Address decode; anything outside the five words answers with an error.
  always_comb begin
    if (hits(paddr, stt_pkg::OFS_CONTROL_STATUS)) begin
      mapped = 1'b1;
    end else if (hits(paddr, stt_pkg::OFS_RELOAD_VALUE)) begin
      mapped = 1'b1;
    end else if (hits(paddr, stt_pkg::OFS_CURRENT_VALUE)) begin
      mapped = 1'b1;
    end else if (hits(paddr, stt_pkg::OFS_IRQ_STATUS)) begin
      mapped = 1'b1;
    end else if (hits(paddr, stt_pkg::OFS_IRQ_MASK)) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pslverr   = psel & penable & ~mapped;
  assign cvr_write = wr_done & hits(paddr, stt_pkg::OFS_CURRENT_VALUE);
  assign csr_read  = rd_done & hits(paddr, stt_pkg::OFS_CONTROL_STATUS);
  assign irq_read  = rd_done & hits(paddr, stt_pkg::OFS_IRQ_STATUS);

  // Tick source: every pclk edge, or a synchronised alternate clock edge.
  assign tick = ctrl[stt_pkg::BIT_ENABLE] &                          // [R12]
                (ctrl[stt_pkg::BIT_CORE_CLK_SEL] | alt_rise);         // [R11] [R17]

  // A software clear takes priority, so it can never look like an expiry.
  assign reaches_zero = tick & ~cvr_write & (current_value == COUNT_W'(stt_pkg::COUNT_ONE)); // [R03]
  assign flag_set     = reaches_zero;
  assign ev_set[stt_pkg::EV_ZERO_REACHED] = reaches_zero;
  assign ev_set[stt_pkg::EV_SW_CLEAR]     = cvr_write;

  // Control bits; the zero flag at bit 16 is read-only and held apart.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= stt_pkg::RST_CONTROL_STATUS[stt_pkg::CTRL_W-1:0];       // [R16]
    end else if (wr_done && hits(paddr, stt_pkg::OFS_CONTROL_STATUS)) begin
      ctrl <= pwdata[stt_pkg::CTRL_W-1:0];
    end
  end

  // Reload register; only the low 24 bits are stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_value <= COUNT_W'(stt_pkg::RST_COUNT);
    end else if (wr_done && hits(paddr, stt_pkg::OFS_RELOAD_VALUE)) begin
      reload_value <= pwdata[COUNT_W-1:0];                           // [R08]
    end
  end

  // The count is architecturally undefined after reset; it is zeroed here only
  // so that the bus never returns unknown bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_value <= COUNT_W'(stt_pkg::RST_COUNT);                 // [R13]
    end else if (cvr_write) begin
      current_value <= COUNT_W'(stt_pkg::COUNT_ZERO);                // [R06] [R01]
    end else if (tick) begin
      if (current_value == COUNT_W'(stt_pkg::COUNT_ZERO)) begin
        current_value <= reload_value;                               // [R02] [R05] [R08]
      end else begin
        current_value <= current_value - COUNT_W'(stt_pkg::COUNT_ONE); // [R02]
      end
    end
  end

  // Zero flag: a new expiry wins over a clear in the same cycle, and a read only
  // clears the flag if the value it returned already showed it set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_reached_flag <= stt_pkg::RST_CONTROL_STATUS[stt_pkg::BIT_ZERO_REACHED];
    end else if (flag_set) begin
      zero_reached_flag <= 1'b1;                                     // [R03]
    end else if (cvr_write || (csr_read && snap_flag)) begin
      zero_reached_flag <= 1'b0;                                     // [R04]
    end
  end

  // Tick exception pend: one pclk pulse per expiry when enabled by bit 1.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_pend <= 1'b0;
    end else begin
      tick_pend <= reaches_zero & ctrl[stt_pkg::BIT_TICK_INT_EN];     // [R09] [R10]
    end
  end

  // Sticky interrupt status; a read clears only the bits it returned.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= stt_pkg::RST_EVENTS;
    end else begin
      irq_status <= ev_set | (irq_status & ~(irq_read ? snap_status : '0));
    end
  end

  // Interrupt mask, same layout as the status register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= stt_pkg::RST_EVENTS;
    end else if (wr_done && hits(paddr, stt_pkg::OFS_IRQ_MASK)) begin
      irq_mask <= pwdata[stt_pkg::EVENT_W-1:0];
    end
  end

  // Level interrupt from registered status and mask.
  assign irq = |(irq_status & irq_mask);

  // Read multiplexer; reserved bits read zero.
  always_comb begin
    next_prdata = '0;
    if (hits(paddr, stt_pkg::OFS_CONTROL_STATUS)) begin
      next_prdata[stt_pkg::CTRL_W-1:0]          = ctrl;
      next_prdata[stt_pkg::BIT_ZERO_REACHED]    = zero_reached_flag;
    end else if (hits(paddr, stt_pkg::OFS_RELOAD_VALUE)) begin
      next_prdata[COUNT_W-1:0] = reload_value;
    end else if (hits(paddr, stt_pkg::OFS_CURRENT_VALUE)) begin
      next_prdata[COUNT_W-1:0] = current_value;                      // [R07] [R15]
    end else if (hits(paddr, stt_pkg::OFS_IRQ_STATUS)) begin
      next_prdata[stt_pkg::EVENT_W-1:0] = irq_status;
    end else if (hits(paddr, stt_pkg::OFS_IRQ_MASK)) begin
      next_prdata[stt_pkg::EVENT_W-1:0] = irq_mask;
    end
  end

  // Read data is captured in the setup cycle, so the access cycle returns a
  // snapshot one cycle old; there is no locking against the running count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata      <= '0;
      snap_flag   <= 1'b0;
      snap_status <= stt_pkg::RST_EVENTS;
    end else if (setup_rd) begin
      prdata      <= next_prdata;                                    // [R15]
      snap_flag   <= zero_reached_flag;
      snap_status <= irq_status;
    end
  end

  // Checks on the counter, flag, pend and interrupt behaviour.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_reload_on_zero;
    (tick && !cvr_write && current_value == '0) |=> (current_value == $past(reload_value));
  endproperty
  a_reload_on_zero: assert property (p_reload_on_zero) // [R02]
    else $error("counter did not reload at zero");

  property p_decrement;
    (tick && !cvr_write && current_value != '0)
      |=> (current_value == $past(current_value) - COUNT_W'(stt_pkg::COUNT_ONE));
  endproperty
  a_decrement: assert property (p_decrement) // [R01]
    else $error("counter did not decrement by one");

  property p_flag_on_one_to_zero;
    (tick && !cvr_write && current_value == COUNT_W'(stt_pkg::COUNT_ONE))
      |=> (zero_reached_flag && current_value == '0);
  endproperty
  a_flag_on_one_to_zero: assert property (p_flag_on_one_to_zero) // [R03]
    else $error("zero flag not set on one to zero");

  property p_write_clears;
    cvr_write |=> (current_value == '0 && !zero_reached_flag && !tick_pend);
  endproperty
  a_write_clears: assert property (p_write_clears) // [R06]
    else $error("current value write did not clear counter and flag");

  property p_read_clears_flag;
    (csr_read && snap_flag && !flag_set) |=> !zero_reached_flag;
  endproperty
  a_read_clears_flag: assert property (p_read_clears_flag) // [R04]
    else $error("control status read did not clear zero flag");

  property p_pend_on_expiry;
    (reaches_zero && ctrl[stt_pkg::BIT_TICK_INT_EN]) |=> tick_pend ##1 !tick_pend;
  endproperty
  a_pend_on_expiry: assert property (p_pend_on_expiry) // [R09]
    else $error("tick exception not pended for one cycle");

  property p_no_pend_without_expiry;
    tick_pend |-> $past(reaches_zero) && $past(ctrl[stt_pkg::BIT_TICK_INT_EN]) && !$past(cvr_write);
  endproperty
  a_no_pend_without_expiry: assert property (p_no_pend_without_expiry) // [R10]
    else $error("tick exception pended without an expiry");

  property p_zero_reload_holds;
    (reload_value == '0 && current_value == '0 && !cvr_write && !wr_done)
      |=> (current_value == '0) [*2];
  endproperty
  a_zero_reload_holds: assert property (p_zero_reload_holds) // [R05]
    else $error("counter left zero with zero reload");

  property p_disabled_stops;
    (!ctrl[stt_pkg::BIT_ENABLE] && !cvr_write) |=> $stable(current_value);
  endproperty
  a_disabled_stops: assert property (p_disabled_stops) // [R12]
    else $error("counter moved while disabled");

  // With the alternate clock selected, the count may only move on a reference edge.
  property p_clock_select;
    (ctrl[stt_pkg::BIT_ENABLE] && !ctrl[stt_pkg::BIT_CORE_CLK_SEL] && !alt_rise && !cvr_write)
      |=> $stable(current_value);
  endproperty
  a_clock_select: assert property (p_clock_select) // [R11]
    else $error("tick source does not follow clock select");

  property p_cvr_upper_zero;
    (rd_done && hits(paddr, stt_pkg::OFS_CURRENT_VALUE)) |-> (prdata[31:COUNT_W] == '0);
  endproperty
  a_cvr_upper_zero: assert property (p_cvr_upper_zero) // [R07]
    else $error("current value upper bits not zero");

  // A mask write in the same cycle may drop the bit, so that case is left out.
  property p_irq_follows_event;
    (reaches_zero && irq_mask[stt_pkg::EV_ZERO_REACHED]
      && !(wr_done && hits(paddr, stt_pkg::OFS_IRQ_MASK))) |=> irq;
  endproperty
  a_irq_follows_event: assert property (p_irq_follows_event)
    else $error("unmasked event did not raise irq");

  property p_zero_event;
    reaches_zero |=> irq_status[stt_pkg::EV_ZERO_REACHED];
  endproperty
  a_zero_event: assert property (p_zero_event) // [R03]
    else $error("expiry did not set its status bit");

  property p_sw_clear_event;
    cvr_write |=> irq_status[stt_pkg::EV_SW_CLEAR];
  endproperty
  a_sw_clear_event: assert property (p_sw_clear_event) // [R06]
    else $error("software clear did not set its status bit");

  property p_no_pend_int_off;
    (reaches_zero && !ctrl[stt_pkg::BIT_TICK_INT_EN]) |=> !tick_pend;
  endproperty
  a_no_pend_int_off: assert property (p_no_pend_int_off) // [R09]
    else $error("tick exception pended with the interrupt enable off");

  property p_reload_write;
    (wr_done && hits(paddr, stt_pkg::OFS_RELOAD_VALUE))
      |=> (reload_value == $past(pwdata[COUNT_W-1:0]));
  endproperty
  a_reload_write: assert property (p_reload_write) // [R08]
    else $error("reload write not stored");

  property p_ctrl_write;
    (wr_done && hits(paddr, stt_pkg::OFS_CONTROL_STATUS))
      |=> (ctrl == $past(pwdata[stt_pkg::CTRL_W-1:0]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) // [R12]
    else $error("control write not stored");

  property p_cvr_snapshot;
    (setup_rd && hits(paddr, stt_pkg::OFS_CURRENT_VALUE))
      |=> (prdata[COUNT_W-1:0] == $past(current_value));
  endproperty
  a_cvr_snapshot: assert property (p_cvr_snapshot) // [R15]
    else $error("current value read did not return the counter snapshot");

  // The edge detector must not stretch one reference edge into two ticks.
  property p_alt_single_pulse;
    alt_rise |=> !alt_rise;
  endproperty
  a_alt_single_pulse: assert property (p_alt_single_pulse) // [R17]
    else $error("alternate clock edge gave more than one tick");

endmodule : stt_system_tick_timer

/* verif/stt_partner.sv */
// Far-side model of the tick timer: exception controller and alternate clock source.
// Assumes pclk and presetn are those of the timer under test.
`timescale 1ns/100ps
module stt_partner (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tick_pend,
  output logic      alt_tick_clk
);
  int pend_count;

  // The exception controller counts each one-cycle pend pulse as one pended exception.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_count <= 0;
    end else if (tick_pend) begin
      pend_count <= pend_count + 1;
    end
  end

  // The reference clock stands low between bursts, so no stray edge reaches the counter.
  initial begin
    alt_tick_clk = 1'b0;
  end

  // Each edge is held four pclk cycles high and low, above the two the synchroniser needs.
  task automatic alt_edges(input int n);
    repeat (n) begin
      @(posedge pclk);
      alt_tick_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      alt_tick_clk <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask : alt_edges
endmodule : stt_partner

/* verif/system_tick_timer_tb_top.sv */
// Self-checking bench for the tick timer: APB master, register table, count scenarios.
// Assumes stt_partner counts pend pulses and drives the alternate clock.
`timescale 1ns/100ps
module system_tick_timer_tb_top;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] w;
    logic [31:0] r;
  } stt_row_t;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        alt_tick_clk;
  logic        tick_pend;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          num_errors;
  int          n_checks;
  int          p0;
  int          i;
  stt_row_t    rows [5] = '{
    '{12'h010, 32'hffff_fffe, 32'h0000_0006},
    '{12'h014, 32'hffff_ffff, 32'h00ff_ffff},
    '{12'h018, 32'h1234_5678, 32'h0000_0000},
    '{12'h100, 32'h0000_0005, 32'h0000_0000},
    '{12'h020, 32'h0000_0003, 32'h0000_0003}};

  stt_system_tick_timer dut (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .pready       (pready),
    .prdata       (prdata),
    .pslverr      (pslverr),
    .alt_tick_clk (alt_tick_clk),
    .tick_pend    (tick_pend),
    .irq          (irq)
  );

  stt_partner u_partner (
    .pclk         (pclk),
    .presetn      (presetn),
    .tick_pend    (tick_pend),
    .alt_tick_clk (alt_tick_clk)
  );

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= w;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // The whole sequence needs well under 2000 cycles; this cuts a hang short.
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, stt_pkg::OFS_CONTROL_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // Table: write each row, read it back, and expect an error only off the map.
    for (i = 0; i < 5; i++) begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0000_0000);
      check(rd, rows[i].r);
      check({31'h0, err}, {31'h0, rows[i].a == 12'h100});
    end
    // The software clear event was masked when it came, so unmasking raises irq.
    @(negedge pclk);
    check({31'h0, irq}, 32'h0000_0001);
    apb(1'b0, stt_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0002);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0000_0000);
    // Count 0 -> load 3 -> 2 -> 1 -> 0, then the pend pulse follows that edge.
    apb(1'b1, stt_pkg::OFS_RELOAD_VALUE, 32'h0000_0003);
    apb(1'b1, stt_pkg::OFS_CURRENT_VALUE, 32'h0000_0000);
    apb(1'b0, stt_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    p0 = u_partner.pend_count;
    apb(1'b1, stt_pkg::OFS_CONTROL_STATUS, 32'h0000_0007);
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    check({31'h0, tick_pend}, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, stt_pkg::OFS_CONTROL_STATUS, 32'h0000_0006);
    apb(1'b0, stt_pkg::OFS_CONTROL_STATUS, 32'h0000_0000);
    check(rd, 32'h0001_0006);
    apb(1'b0, stt_pkg::OFS_CONTROL_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0006);
    // Stopped counter holds the value it had when the enable fell.
    apb(1'b0, stt_pkg::OFS_CURRENT_VALUE, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    repeat (10) @(posedge pclk);
    apb(1'b0, stt_pkg::OFS_CURRENT_VALUE, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    apb(1'b0, stt_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    // Zero crossing with the pend disabled, then a clear write with it enabled.
    apb(1'b1, stt_pkg::OFS_CONTROL_STATUS, 32'h0000_0005);
    apb(1'b1, stt_pkg::OFS_CONTROL_STATUS, 32'h0000_0006);
    apb(1'b1, stt_pkg::OFS_CURRENT_VALUE, 32'hffff_ffff);
    apb(1'b0, stt_pkg::OFS_CONTROL_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0006);
    check(u_partner.pend_count, p0 + 1);
    // A zero reload keeps the counter at zero and never crosses from one.
    apb(1'b1, stt_pkg::OFS_RELOAD_VALUE, 32'h0000_0000);
    apb(1'b1, stt_pkg::OFS_CURRENT_VALUE, 32'h0000_0000);
    apb(1'b1, stt_pkg::OFS_CONTROL_STATUS, 32'h0000_0005);
    repeat (20) @(posedge pclk);
    apb(1'b0, stt_pkg::OFS_CURRENT_VALUE, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, stt_pkg::OFS_CONTROL_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0005);
    // Alternate clock: five edges give load 100 and four decrements.
    apb(1'b1, stt_pkg::OFS_RELOAD_VALUE, 32'h0000_0064);
    apb(1'b1, stt_pkg::OFS_CONTROL_STATUS, 32'h0000_0001);
    apb(1'b1, stt_pkg::OFS_CURRENT_VALUE, 32'h0000_0000);
    u_partner.alt_edges(5);
    repeat (10) @(posedge pclk);
    apb(1'b0, stt_pkg::OFS_CURRENT_VALUE, 32'h0000_0000);
    check(rd, 32'h0000_0060);
    // A reset in mid-run must return the enabled control register to zero.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, stt_pkg::OFS_CONTROL_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    end_sim();
  end
endmodule : system_tick_timer_tb_top
